// ==== design/frt_pkg.sv ====
// frt_pkg: constants and types for the free-running capture timer.
// assumes byte registers on an 8-bit address space.
package frt_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned PRE_W  = 2;

  localparam logic [7:0] OFS_CTRL    = 8'h12;
  localparam logic [7:0] OFS_STATUS  = 8'h13;
  localparam logic [7:0] OFS_CAP_HI  = 8'h14;
  localparam logic [7:0] OFS_CAP_LO  = 8'h15;
  localparam logic [7:0] OFS_CAP_CFG = 8'h16;
  localparam logic [7:0] OFS_CNT_HI  = 8'h18;
  localparam logic [7:0] OFS_CNT_LO  = 8'h19;
  localparam logic [7:0] OFS_ALT_HI  = 8'h1A;
  localparam logic [7:0] OFS_ALT_LO  = 8'h1B;

  // bit positions
  localparam int unsigned BIT_CAP_IE   = 7;
  localparam int unsigned BIT_WRAP_IE  = 5;
  localparam int unsigned BIT_EDGE     = 1;
  localparam int unsigned BIT_CAP_FLAG = 7;
  localparam int unsigned BIT_WRAP_FLG = 5;
  localparam int unsigned BIT_CMP_SEL  = 0;

  localparam logic [15:0] CNT_RESET  = 16'hFFFC;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [1:0]  PRE_LAST   = 2'h3;
  localparam logic [7:0]  READ_ZERO  = 8'h00;
  localparam int unsigned STARTUP_DEF = 4064;

  typedef struct packed {
    logic cap_irq_enable;
    logic wrap_irq_enable;
    logic cmp_select;
  } frt_ctrl_s;
endpackage : frt_pkg

// ==== design/frt_timer.sv ====
// frt_timer: 16-bit free-running counter, prescaler, coherent byte
// reads, wrap flag, input capture front end.
// assumes one clock, synchronous bus master, capture pins asynchronous.
`timescale 1ns/1ps
module frt_timer #(
  parameter int unsigned STARTUP_CYCLES = frt_pkg::STARTUP_DEF
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       cap_schmitt_i,
  input  wire logic       cap_comparator_i,
  output logic            cmp_enable_o,
  output logic            irq_o
);
  localparam int unsigned SU_W = $clog2(STARTUP_CYCLES + 1);
  localparam logic [SU_W-1:0] SU_LAST = SU_W'(STARTUP_CYCLES);

  logic [SU_W-1:0]  su_cnt;
  logic             running;
  logic [1:0]       pre;
  logic             tick;
  logic [15:0]      count;
  frt_pkg::frt_ctrl_s ctrl;
  logic             edge_sel;
  logic             wrap_flag;
  logic             cap_flag;
  logic             wrap_armed;
  logic             cap_armed;
  logic [7:0]       lo_hold;
  logic             lo_frozen;
  logic [7:0]       alt_hold;
  logic             alt_frozen;
  logic [15:0]      cap_val;
  logic             cap_inhibit;
  logic [1:0]       sch_sync;
  logic [1:0]       cmp_sync;
  logic             cap_now;
  logic             cap_prev;
  logic             cap_edge;

  // bus decode
  logic rd_ctrl, rd_stat, rd_chi, rd_clo, rd_ahi, rd_alo, rd_pchi, rd_pclo;
  assign rd_ctrl = rd_i && addr_i == frt_pkg::OFS_CTRL;
  assign rd_stat = rd_i && addr_i == frt_pkg::OFS_STATUS;
  assign rd_chi  = rd_i && addr_i == frt_pkg::OFS_CNT_HI;
  assign rd_clo  = rd_i && addr_i == frt_pkg::OFS_CNT_LO;
  assign rd_ahi  = rd_i && addr_i == frt_pkg::OFS_ALT_HI;
  assign rd_alo  = rd_i && addr_i == frt_pkg::OFS_ALT_LO;
  assign rd_pchi = rd_i && addr_i == frt_pkg::OFS_CAP_HI;
  assign rd_pclo = rd_i && addr_i == frt_pkg::OFS_CAP_LO;

  // start-up delay after reset release
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      su_cnt  <= '0;
      running <= 1'b0;
    end else if (!running) begin
      su_cnt  <= su_cnt + 1'b1;
      running <= su_cnt == SU_LAST - 1'b1;
    end
  end

  // prescaler; tick marks the cycle the count moves
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) pre <= '0;
    else if (running) pre <= pre + 1'b1;
  end
  assign tick = running && pre == frt_pkg::PRE_LAST;

  // count changes only on tick; bus writes never reach it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) count <= frt_pkg::CNT_RESET;
    else if (tick) count <= count + 1'b1;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) ctrl <= '0;
    else if (wr_i && addr_i == frt_pkg::OFS_CTRL) begin
      ctrl.cap_irq_enable  <= wdata_i[frt_pkg::BIT_CAP_IE];
      ctrl.wrap_irq_enable <= wdata_i[frt_pkg::BIT_WRAP_IE];
    end else if (wr_i && addr_i == frt_pkg::OFS_CAP_CFG)
      ctrl.cmp_select <= wdata_i[frt_pkg::BIT_CMP_SEL];
  end

  // edge select survives reset, so no reset term here
  always_ff @(posedge clk_sys_i) begin
    if (wr_i && addr_i == frt_pkg::OFS_CTRL)
      edge_sel <= wdata_i[frt_pkg::BIT_EDGE];
  end

  // coherent low-byte latches, primary and alternate
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_frozen <= 1'b0;
      lo_hold   <= '0;
    end else if (rd_chi) begin
      if (!lo_frozen) lo_hold <= count[7:0];
      lo_frozen <= 1'b1;
    end else if (rd_clo) lo_frozen <= 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alt_frozen <= 1'b0;
      alt_hold   <= '0;
    end else if (rd_ahi) begin
      if (!alt_frozen) alt_hold <= count[7:0];
      alt_frozen <= 1'b1;
    end else if (rd_alo) alt_frozen <= 1'b0;
  end

  // flags are not reset; set beats a same-cycle clear
  logic wrap_set;
  assign wrap_set = tick && count == frt_pkg::CNT_MAX;
  always_ff @(posedge clk_sys_i) begin
    if (wrap_set) wrap_flag <= 1'b1;
    else if (rd_clo && wrap_armed) wrap_flag <= 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) wrap_armed <= 1'b0;
    else if (rd_stat && wrap_flag) wrap_armed <= 1'b1;
    else if (rd_clo) wrap_armed <= 1'b0;
  end

  // capture front end; input mux after the synchronisers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sch_sync <= '0;
      cmp_sync <= '0;
    end else begin
      sch_sync <= {sch_sync[0], cap_schmitt_i};
      cmp_sync <= {cmp_sync[0], cap_comparator_i};
    end
  end
  // switching the path can look like an edge; software masks it first
  assign cap_now = ctrl.cmp_select ? cmp_sync[1] : sch_sync[1];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) cap_prev <= 1'b0;
    else cap_prev <= cap_now;
  end
  assign cap_edge = edge_sel ? (cap_now && !cap_prev)
                             : (!cap_now && cap_prev);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) cap_inhibit <= 1'b0;
    else if (rd_pchi) cap_inhibit <= 1'b1;
    else if (rd_pclo) cap_inhibit <= 1'b0;
  end

  // capture value and flag are untouched by reset
  always_ff @(posedge clk_sys_i) begin
    if (cap_edge && !cap_inhibit) cap_val <= count;
  end

  always_ff @(posedge clk_sys_i) begin
    if (cap_edge) cap_flag <= 1'b1;
    else if (rd_pclo && cap_armed) cap_flag <= 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) cap_armed <= 1'b0;
    else if (rd_stat && cap_flag) cap_armed <= 1'b1;
    else if (rd_pclo) cap_armed <= 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o        <= 1'b0;
      cmp_enable_o <= 1'b0;
    end else begin
      irq_o <= (wrap_flag && ctrl.wrap_irq_enable)
             || (cap_flag && ctrl.cap_irq_enable);
      cmp_enable_o <= ctrl.cmp_select;
    end
  end

  // read data: one cycle after the strobe, zero otherwise
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = frt_pkg::READ_ZERO;
    if (rd_i) begin
      unique case (addr_i)
        frt_pkg::OFS_CTRL: begin
          next_rdata[frt_pkg::BIT_CAP_IE]  = ctrl.cap_irq_enable;
          next_rdata[frt_pkg::BIT_WRAP_IE] = ctrl.wrap_irq_enable;
          next_rdata[frt_pkg::BIT_EDGE]    = edge_sel;
        end
        frt_pkg::OFS_STATUS: begin
          next_rdata[frt_pkg::BIT_CAP_FLAG] = cap_flag;
          next_rdata[frt_pkg::BIT_WRAP_FLG] = wrap_flag;
        end
        frt_pkg::OFS_CAP_CFG:
          next_rdata[frt_pkg::BIT_CMP_SEL] = ctrl.cmp_select;
        frt_pkg::OFS_CAP_HI: next_rdata = cap_val[15:8];
        frt_pkg::OFS_CAP_LO: next_rdata = cap_val[7:0];
        frt_pkg::OFS_CNT_HI: next_rdata = count[15:8];
        frt_pkg::OFS_CNT_LO:
          next_rdata = lo_frozen ? lo_hold : count[7:0];
        frt_pkg::OFS_ALT_HI: next_rdata = count[15:8];
        frt_pkg::OFS_ALT_LO:
          next_rdata = alt_frozen ? alt_hold : count[7:0];
        default: next_rdata = frt_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_o <= '0;
    else rdata_o <= next_rdata;
  end

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_status_seen;
    rd_stat && wrap_flag;
  endsequence
  sequence s_low_read;
    rd_clo && !wrap_set;
  endsequence
  sequence s_cap_seen;
    rd_stat && cap_flag;
  endsequence

  a_prescale_step: assert property (
    tick |=> !tick [*3] ##1 tick)
    else $error("counter step not every four clocks");

  a_count_stable: assert property (
    !tick |=> count == $past(count))
    else $error("count changed without prescaler tick");

  a_wrap_flag_set: assert property (
    wrap_set |=> wrap_flag && count == 16'h0000)
    else $error("wrap did not set flag");

  a_wrap_clear_seq: assert property (
    wrap_armed && s_low_read |=> !wrap_flag)
    else $error("wrap flag not cleared by sequence");

  a_wrap_only_clear: assert property (
    $fell(wrap_flag) |-> $past(rd_clo) && $past(wrap_armed))
    else $error("wrap flag cleared without sequence");

  a_alt_no_flag: assert property (
    (rd_ahi || rd_alo) && !wrap_set |=> wrap_flag == $past(wrap_flag))
    else $error("alternate read changed wrap flag");

  a_low_frozen: assert property (
    lo_frozen && rd_clo |=> rdata_o == lo_hold)
    else $error("low byte not frozen after high read");

  a_irq_level: assert property (
    wrap_flag && ctrl.wrap_irq_enable |=> irq_o)
    else $error("interrupt missing with flag and enable");

  a_capture_latch: assert property (
    cap_edge && !cap_inhibit |=> cap_val == $past(count) && cap_flag)
    else $error("capture did not latch count");

  a_capture_hold: assert property (
    cap_inhibit |=> cap_val == $past(cap_val))
    else $error("capture changed while inhibited");

  a_cmp_route: assert property (
    ctrl.cmp_select ##1 ctrl.cmp_select |-> cmp_enable_o)
    else $error("comparator reference not enabled");

  a_wrap_arm: assert property (
    s_status_seen |=> wrap_armed)
    else $error("status read did not arm wrap clear");

  a_wrap_hold: assert property (
    wrap_flag && !(rd_clo && wrap_armed) |=> wrap_flag)
    else $error("wrap flag dropped without clear sequence");

  a_low_keep: assert property (
    lo_frozen && rd_chi |=> lo_frozen && lo_hold == $past(lo_hold))
    else $error("repeated high read moved frozen low byte");

  a_low_live: assert property (
    !lo_frozen && rd_clo |=> rdata_o == $past(count[7:0]))
    else $error("low byte not live before high read");

  a_high_freeze: assert property (
    !lo_frozen && rd_chi |=> lo_frozen && lo_hold == $past(count[7:0]))
    else $error("high read did not freeze low byte");

  a_alt_frozen: assert property (
    alt_frozen && rd_alo |=> rdata_o == alt_hold)
    else $error("alternate low byte not frozen");

  a_alt_keep: assert property (
    alt_frozen && rd_ahi |=> alt_hold == $past(alt_hold))
    else $error("repeated alternate high read moved low byte");

  a_alt_high: assert property (
    rd_ahi |=> rdata_o == $past(count[15:8]))
    else $error("alternate high byte differs from count");

  a_alt_no_arm: assert property (
    rd_ahi || rd_alo |=> wrap_armed == $past(wrap_armed))
    else $error("alternate read touched wrap clear state");

  a_count_reset: assert property (
    !running |-> count == frt_pkg::CNT_RESET)
    else $error("count moved during start-up delay");

  a_startup_idle: assert property (
    !running |-> pre == 2'h0)
    else $error("prescaler ran during start-up delay");

  a_count_step: assert property (
    tick |=> count == $past(count) + 16'h0001)
    else $error("count did not step by one");

  a_cap_arm: assert property (
    s_cap_seen |=> cap_armed)
    else $error("status read did not arm capture clear");

  a_cap_flag_set: assert property (
    cap_edge |=> cap_flag)
    else $error("capture edge did not set flag");

  a_cap_clear: assert property (
    cap_armed && rd_pclo && !cap_edge |=> !cap_flag)
    else $error("capture flag not cleared by sequence");

  a_cap_keep: assert property (
    cap_flag && !(rd_pclo && cap_armed) |=> cap_flag)
    else $error("capture flag dropped without clear sequence");

  a_irq_cap: assert property (
    cap_flag && ctrl.cap_irq_enable |=> irq_o)
    else $error("capture interrupt missing");

  a_irq_quiet: assert property (
    !ctrl.wrap_irq_enable && !ctrl.cap_irq_enable |=> !irq_o)
    else $error("interrupt raised with enables clear");

  a_cmp_off: assert property (
    !ctrl.cmp_select ##1 !ctrl.cmp_select |-> !cmp_enable_o)
    else $error("comparator enabled on trigger path");

  a_inhibit_set: assert property (
    rd_pchi |=> cap_inhibit)
    else $error("capture high read did not inhibit");

  a_rdata_idle: assert property (
    !rd_i |=> rdata_o == frt_pkg::READ_ZERO)
    else $error("read data not zero without read");
endmodule : frt_timer

// ==== tb/frt_cap_src.sv ====
// frt_cap_src: far-side model of the capture pin conditioning paths.
// assumes the bench sets the pin level just after a clock edge.
`timescale 1ns/1ps
module frt_cap_src (
  input  wire logic clk_i,
  input  wire logic cmp_on_i,
  input  wire logic pin_i,
  output logic      schmitt_o,
  output logic      comparator_o
);
  logic noise = 1'b0;
  // a path that is switched off has no defined level
  always @(posedge clk_i) noise <= ~noise;
  assign comparator_o = cmp_on_i ? pin_i : noise;
  assign schmitt_o    = cmp_on_i ? noise : pin_i;
endmodule : frt_cap_src

// ==== tb/frt_timer_tb.sv ====
// frt_timer_tb: self-checking bench for the free-running capture timer.
// assumes the byte register bus and a start-up delay of 4 clocks.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
  end end
module frt_timer_tb;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        pin = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic [7:0]  rdata_o, d, h;
  logic        cap_schmitt_i, cap_comparator_i, cmp_enable_o, irq_o;
  logic [15:0] v0, c;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          t0, t, te;

  frt_timer #(.STARTUP_CYCLES(4)) i_dut (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .cap_schmitt_i(cap_schmitt_i),
    .cap_comparator_i(cap_comparator_i), .cmp_enable_o(cmp_enable_o),
    .irq_o(irq_o));
  frt_cap_src i_src (.clk_i(clk_sys_i), .cmp_on_i(cmp_enable_o),
    .pin_i(pin), .schmitt_o(cap_schmitt_i), .comparator_o(cap_comparator_i));

  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // model count at a take edge, exact when aligned to the reference
  function automatic logic [15:0] cnt(int tt);
    return 16'(int'(v0) + (tt - t0) / 4);
  endfunction : cnt

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    t = cyc;
    v = rdata_o;
  endtask : rd
  task automatic stat(logic [7:0] m, logic [7:0] e);
    rd(8'h13, d);
    `CHK(d & m, e)
  endtask : stat
  task automatic clr_cap;
    rd(8'h13, d);
    rd(8'h15, d);
  endtask : clr_cap
  task automatic edge_to(logic v);
    @(posedge clk_sys_i);
    pin <= v;
    #1;
    te = cyc;
    tick(6);
  endtask : edge_to
  // high read, repeated high reads, then low read of one byte pair
  task automatic pair(logic [7:0] a);
    while ((cyc + 2 - t0) % 4 != 0) tick(1);
    rd(a, h);
    c = cnt(t);
    `CHK(h, c[15:8])
    repeat (4) rd(a, h);
    rd(a + 8'h01, d);
    `CHK(d, c[7:0])
    while ((cyc + 2 - t0) % 4 != 0) tick(1);
    rd(a + 8'h01, d);
    c = cnt(t);
    `CHK(d, c[7:0])
  endtask : pair
  task automatic reset_chk;
    rd(8'h18, h);
    rd(8'h19, d);
    `CHK({h, d}, frt_pkg::CNT_RESET)
  endtask : reset_chk

  initial begin
    void'($urandom(4));
    tick(4);
    rst_n_i <= 1'b1;
    reset_chk();
    tick(40);
    rd(8'h18, h);
    t0 = t;
    rd(8'h19, d);
    v0 = {h, d};
    `CHK(irq_o, 1'b0)
    wr(8'h12, 8'h20);
    tick(2);
    `CHK(irq_o, 1'b1)
    rd(8'h19, d);
    stat(8'h20, 8'h20);
    rd(8'h1B, d);
    stat(8'h20, 8'h20);
    rd(8'h19, d);
    stat(8'h20, 8'h00);
    `CHK(irq_o, 1'b0)
    rd(8'h12, d);
    `CHK(d & 8'hA2, 8'h20)
    rd(8'h40, d);
    `CHK(d, 8'h00)
    for (int i = 0; i < 4; i++) wr(8'h18 + 8'(i), 8'($urandom));
    tick($urandom_range(3, 30));
    pair(8'h18);
    tick($urandom_range(3, 30));
    pair(8'h1A);
    stat(8'h20, 8'h00);
    wr(8'h16, 8'h00);
    wr(8'h12, 8'h02);
    edge_to(1'b1);
    stat(8'h80, 8'h80);
    rd(8'h14, h);
    rd(8'h15, d);
    c = {h, d} - cnt(te);
    `CHK(c <= 16'h0002, 1'b1)
    tick(8);
    stat(8'h80, 8'h00);
    edge_to(1'b0);
    stat(8'h80, 8'h00);
    wr(8'h12, 8'h80);
    edge_to(1'b1);
    `CHK(irq_o, 1'b0)
    edge_to(1'b0);
    `CHK(irq_o, 1'b1)
    wr(8'h12, 8'h00);
    clr_cap();
    wr(8'h16, 8'h01);
    tick(2);
    `CHK(cmp_enable_o, 1'b1)
    clr_cap();
    tick(8);
    stat(8'h80, 8'h00);
    wr(8'h12, 8'h02);
    edge_to(1'b1);
    stat(8'h80, 8'h80);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    tick(2);
    `CHK(cmp_enable_o, 1'b0)
    rst_n_i <= 1'b1;
    reset_chk();
    rd(8'h12, d);
    `CHK(d & 8'hA2, 8'h02)
    end_sim();
  end
endmodule : frt_timer_tb
